// ===== src/ofr_overtemp_fault.sv
/*
  Over-temperature fault response: threshold and action settings, command port, retry sequencer.
  Assumes a management-link front end that turns link transactions into one-cycle commands,
  a temperature reading in Linear format on the same clock, and the control pin and bias-good
  signal arriving asynchronously.
*/
// Summary of operation
// - Holds a 16-bit Linear-format over-temperature threshold in degrees Celsius.
// - Action 00 keeps operating without interruption on a fault.
// - Action 01 keeps operating for the delay, then applies retry setting if fault remains.
// - Action 10 disables the output at once, then follows the retry setting.
// - Action 11 keeps the output off until the latched fault is cleared.
// - Fault clears by status bit, clear command, reset, off-then-on command, or bias loss.
// - Retry code 000 makes no restart; output stays off until cleared.
// - Codes 001 to 110 try that many restarts, then stay off until cleared.
// - Starts of successive restart attempts are spaced by the programmed delay.
// - Code 111 retries without limit until commanded off, bias lost, or other fault.
// - Delay field n means two to the n units, from 1 to 128.
// - One delay unit comes from the separate timing register.
`timescale 1ns/1ps
`include "ofr_defs.svh"

module ofr_overtemp_fault
  import ofr_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `OFR_TICK_NS / `OFR_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Command port from the management-link front end
  input  wire logic        cmdValid,
  input  wire logic        cmdWrite,
  input  wire logic [7:0]  cmdCode,
  input  wire logic [15:0] cmdWrData,
  output logic             cmdAck,
  output logic             cmdError,
  output logic [15:0]      cmdRdData,
  // Measurement and other protections
  input  wire logic [15:0] tempReading,
  input  wire logic        otherFault,
  // On/off command sources
  input  wire logic        ctrlPin,
  input  wire logic        operationOn,
  input  wire logic        biasGood,
  // Output stage and status
  output logic             outputEnable,
  output logic             faultActive,
  output logic             retrying
);

  // Linear format to signed fixed point with 16 fraction bits
  function automatic logic signed [47:0] linToFixed(input logic [15:0] v);
    logic signed [47:0] w;
    logic [5:0]         sh;
    w  = {{37{v[10]}}, v[10:0]};
    sh = 6'({v[15], v[15:11]} + 6'd16);
    return w <<< sh;
  endfunction

  // Pin synchronisers
  logic [1:0] ctrlSync_ff;
  logic [1:0] biasSync_ff;
  logic       ctrlOn;
  logic       biasOk;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrlSync_ff <= 2'h0;
      biasSync_ff <= 2'h0;
    end else begin
      ctrlSync_ff <= {ctrlSync_ff[0], ctrlPin};
      biasSync_ff <= {biasSync_ff[0], biasGood};
    end
  end

  assign ctrlOn = ctrlSync_ff[1];
  assign biasOk = biasSync_ff[1];

  // Command state and edges
  logic cmdOn;
  logic cmdOn_ff;
  logic overTemp;
  logic clearEvt;
  logic faultEvt;

  assign cmdOn    = ctrlOn && operationOn && biasOk;

  // Registers
  logic [15:0] thresh_ff;
  logic [15:0] nxt_thresh;
  logic [7:0]  action_ff;
  logic [7:0]  nxt_action;
  logic [15:0] timing_ff;
  logic [15:0] nxt_timing;
  logic        faultFlag_ff;
  logic        nxt_faultFlag;
  logic        wrEn;
  logic        stClearBit;
  logic        clearCmd;

  assign wrEn       = cmdValid && cmdWrite;
  assign stClearBit = wrEn && (cmdCode == `OFR_ADDR_STATUS) && cmdWrData[`OFR_ST_FAULT];
  assign clearCmd   = wrEn && (cmdCode == `OFR_CMD_CLEAR);
  // Off-then-on is seen as the rise of the combined on command
  assign clearEvt   = stClearBit || clearCmd || (cmdOn && !cmdOn_ff) || !biasOk;
  assign overTemp   = linToFixed(tempReading) >= linToFixed(thresh_ff);

  always_comb begin
    nxt_thresh = thresh_ff;
    nxt_action = action_ff;
    nxt_timing = timing_ff;
    if (wrEn && (cmdCode == `OFR_ADDR_THRESH)) begin
      nxt_thresh = cmdWrData;
    end
    if (wrEn && (cmdCode == `OFR_ADDR_ACTION)) begin
      nxt_action = cmdWrData[7:0];
    end
    if (wrEn && (cmdCode == `OFR_ADDR_TIMING)) begin
      nxt_timing = cmdWrData;
    end
    // A new fault in the clearing cycle wins
    nxt_faultFlag = faultEvt || (faultFlag_ff && !clearEvt);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      thresh_ff    <= `OFR_RST_THRESH;
      action_ff    <= `OFR_RST_ACTION;
      timing_ff    <= `OFR_RST_TIMING;
      faultFlag_ff <= 1'b0;
      cmdOn_ff     <= 1'b0;
    end else begin
      thresh_ff    <= nxt_thresh;
      action_ff    <= nxt_action;
      timing_ff    <= nxt_timing;
      faultFlag_ff <= nxt_faultFlag;
      cmdOn_ff     <= cmdOn;
    end
  end

  // Fields
  ofr_action_t actField;
  logic [2:0]  retryField;
  logic [2:0]  dlyField;

  assign actField   = ofr_action_t'(action_ff[`OFR_ACT_MSB:`OFR_ACT_LSB]);
  assign retryField = action_ff[`OFR_RETRY_MSB:`OFR_RETRY_LSB];
  assign dlyField   = action_ff[`OFR_DLY_MSB:`OFR_DLY_LSB];

  // Retry sequencer
  ofr_state_t state_ff;
  ofr_state_t nxt_state;
  logic [2:0] attempts_ff;
  logic [2:0] nxt_attempts;
  logic       outEn_ff;
  logic       nxt_outEn;
  logic       tmrStart;
  logic       tmrRetry;
  logic       tmrBusy;
  logic [7:0] tmrUnit;

  assign tmrUnit = tmrRetry ? timing_ff[`OFR_TUNIT_RETRY_MSB:`OFR_TUNIT_RETRY_LSB]
                            : timing_ff[`OFR_TUNIT_CONT_MSB:`OFR_TUNIT_CONT_LSB];

  always_comb begin
    nxt_state    = state_ff;
    nxt_attempts = attempts_ff;
    tmrStart     = 1'b0;
    tmrRetry     = 1'b1;
    faultEvt     = 1'b0;
    unique case (state_ff)
      ST_RUN: begin
        nxt_attempts = 3'h0;
        if (cmdOn && overTemp) begin
          faultEvt = 1'b1;
          unique case (actField)
            ACT_IGNORE: begin
              nxt_state = ST_RUN;
            end
            ACT_CONTINUE: begin
              nxt_state = ST_CONTINUE;
              tmrStart  = 1'b1;
              tmrRetry  = 1'b0;
            end
            ACT_DISABLE: begin
              if (retryField == `OFR_RETRY_NONE) begin
                nxt_state = ST_LATCHED;
              end else begin
                nxt_state = ST_DELAY;
                tmrStart  = 1'b1;
              end
            end
            ACT_LATCH: begin
              nxt_state = ST_LATCHED;
            end
          endcase
        end
      end
      ST_CONTINUE: begin
        tmrRetry = 1'b0;
        if (!overTemp) begin
          nxt_state = ST_RUN;
        end else if (!tmrBusy) begin
          // Still hot after the delay: act on the retry setting
          if (retryField == `OFR_RETRY_NONE) begin
            nxt_state = ST_LATCHED;
          end else begin
            nxt_state = ST_DELAY;
            tmrStart  = 1'b1;
            tmrRetry  = 1'b1;
          end
        end
      end
      ST_DELAY: begin
        // The timer runs from the start of the last attempt, so starts are one delay apart
        if (!tmrBusy) begin
          nxt_state    = ST_ATTEMPT;
          nxt_attempts = 3'(attempts_ff + 3'h1);
          tmrStart     = 1'b1;
        end
      end
      ST_ATTEMPT: begin
        if (overTemp) begin
          faultEvt = 1'b1;
          if ((retryField == `OFR_RETRY_FOREVER) || (attempts_ff < retryField)) begin
            nxt_state = ST_DELAY;
          end else begin
            nxt_state = ST_LATCHED;
          end
        end else if (!tmrBusy) begin
          nxt_state = ST_RUN;
        end
      end
      ST_LATCHED: begin
        if (clearEvt && !faultFlag_ff) begin
          nxt_state = ST_RUN;
        end else if (clearEvt) begin
          nxt_state = ST_RUN;
        end
      end
    endcase
    // Commanded off, bias lost or another protection stops any retry sequence
    if (!cmdOn) begin
      nxt_state    = ST_RUN;
      nxt_attempts = 3'h0;
      tmrStart     = 1'b0;
    end else if (otherFault && ((state_ff == ST_DELAY) || (state_ff == ST_ATTEMPT))) begin
      nxt_state = ST_LATCHED;
      tmrStart  = 1'b0;
    end
    nxt_outEn = cmdOn && ((nxt_state == ST_RUN) || (nxt_state == ST_CONTINUE) || (nxt_state == ST_ATTEMPT));
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff    <= ST_RUN;
      attempts_ff <= 3'h0;
      outEn_ff    <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      attempts_ff <= nxt_attempts;
      outEn_ff    <= nxt_outEn;
    end
  end

  ofr_delay_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk       (clk),
    .resetn    (resetn),
    .start     (tmrStart),
    .unitCount (tmrUnit),
    .exponent  (dlyField),
    .busy      (tmrBusy)
  );

  // Command answers, registered one cycle after the request
  logic        ack_ff;
  logic        nxt_ack;
  logic        err_ff;
  logic        nxt_err;
  logic [15:0] rd_ff;
  logic [15:0] nxt_rd;
  logic [15:0] statusWord;

  assign statusWord = {8'h00,
                       (state_ff == ST_DELAY) || (state_ff == ST_ATTEMPT),
                       attempts_ff,
                       2'h0,
                       (state_ff == ST_LATCHED) || (state_ff == ST_DELAY),
                       faultFlag_ff};

  always_comb begin
    nxt_ack = cmdValid;
    nxt_err = 1'b0;
    nxt_rd  = rd_ff;
    if (cmdValid) begin
      unique case (cmdCode)
        `OFR_ADDR_THRESH: nxt_rd = cmdWrite ? rd_ff : thresh_ff;
        `OFR_ADDR_ACTION: nxt_rd = cmdWrite ? rd_ff : {8'h00, action_ff};
        `OFR_ADDR_TIMING: nxt_rd = cmdWrite ? rd_ff : timing_ff;
        `OFR_ADDR_STATUS: nxt_rd = cmdWrite ? rd_ff : statusWord;
        `OFR_CMD_CLEAR: begin
          nxt_err = !cmdWrite;
          nxt_rd  = cmdWrite ? rd_ff : 16'h0000;
        end
        default: begin
          // Unmapped codes are refused and read back as zero
          nxt_err = 1'b1;
          nxt_rd  = cmdWrite ? rd_ff : 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      rd_ff  <= 16'h0000;
    end else begin
      ack_ff <= nxt_ack;
      err_ff <= nxt_err;
      rd_ff  <= nxt_rd;
    end
  end

  assign cmdAck       = ack_ff;
  assign cmdError     = err_ff;
  assign cmdRdData    = rd_ff;
  assign outputEnable = outEn_ff;
  assign faultActive  = faultFlag_ff;
  assign retrying     = statusWord[`OFR_ST_RETRYING];

endmodule // ofr_overtemp_fault

// ===== src/ofr_defs.svh
/*
  Offsets, field positions, reset values and timing counts of the over-temperature fault block.
  Assumes it is included by bare name before the package and the modules that use it.
*/
`ifndef OFR_DEFS_SVH
`define OFR_DEFS_SVH

// Command codes
`define OFR_ADDR_THRESH     8'h4F
`define OFR_ADDR_ACTION     8'h50
`define OFR_ADDR_TIMING     8'hD2
`define OFR_ADDR_STATUS     8'hE0
`define OFR_CMD_CLEAR       8'hE1

// Action register fields
`define OFR_ACT_MSB         7
`define OFR_ACT_LSB         6
`define OFR_RETRY_MSB       5
`define OFR_RETRY_LSB       3
`define OFR_DLY_MSB         2
`define OFR_DLY_LSB         0
`define OFR_RETRY_NONE      3'h0
`define OFR_RETRY_FOREVER   3'h7

// Timing register fields, one unit each in milliseconds
`define OFR_TUNIT_CONT_MSB  7
`define OFR_TUNIT_CONT_LSB  0
`define OFR_TUNIT_RETRY_MSB 15
`define OFR_TUNIT_RETRY_LSB 8

// Status register fields
`define OFR_ST_FAULT        0
`define OFR_ST_DISABLED     1
`define OFR_ST_ATT_MSB      6
`define OFR_ST_ATT_LSB      4
`define OFR_ST_RETRYING     7

// Reset values
`define OFR_RST_THRESH      16'h7BFF
`define OFR_RST_ACTION      8'h00
`define OFR_RST_TIMING      16'h0A0A

// Timing
`define OFR_CLK_PERIOD_NS   25
`define OFR_TICK_NS         1000000

`endif

// ===== src/ofr_pkg.sv
/*
  Types of the over-temperature fault block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ofr_pkg;

  typedef enum logic [1:0] {
    ACT_IGNORE  = 2'h0,
    ACT_CONTINUE = 2'h1,
    ACT_DISABLE = 2'h2,
    ACT_LATCH   = 2'h3
  } ofr_action_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_CONTINUE,
    ST_DELAY,
    ST_ATTEMPT,
    ST_LATCHED
  } ofr_state_t;

endpackage

// ===== src/ofr_delay_timer.sv
/*
  Delay timer: counts unitCount milliseconds times two to the power exponent.
  Assumes a start pulse from logic on the same clock; start while busy reloads.
*/
`timescale 1ns/1ps
`include "ofr_defs.svh"

module ofr_delay_timer #(
  parameter int unsigned TICK_CYCLES = `OFR_TICK_NS / `OFR_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Control
  input  wire logic       start,
  input  wire logic [7:0] unitCount,
  input  wire logic [2:0] exponent,
  // Status
  output logic            busy
);

  logic [15:0] preCnt_ff;
  logic [15:0] nxt_preCnt;
  logic [14:0] remain_ff;
  logic [14:0] nxt_remain;
  logic        busy_ff;
  logic        nxt_busy;
  logic        msTick;

  assign msTick = busy_ff && (preCnt_ff == 16'(TICK_CYCLES - 1));

  always_comb begin
    nxt_preCnt = preCnt_ff;
    nxt_remain = remain_ff;
    nxt_busy   = busy_ff;
    if (start) begin
      // A zero unit would wrap the count instead of ending, so it counts as one
      nxt_remain = 15'({7'h00, (unitCount == 8'h00) ? 8'h01 : unitCount} << exponent);
      nxt_preCnt = 16'h0000;
      nxt_busy   = 1'b1;
    end else if (busy_ff) begin
      nxt_preCnt = msTick ? 16'h0000 : 16'(preCnt_ff + 16'h0001);
      if (msTick) begin
        nxt_remain = 15'(remain_ff - 15'h0001);
        if (remain_ff == 15'h0001) begin
          nxt_busy = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      preCnt_ff <= 16'h0000;
      remain_ff <= 15'h0000;
      busy_ff   <= 1'b0;
    end else begin
      preCnt_ff <= nxt_preCnt;
      remain_ff <= nxt_remain;
      busy_ff   <= nxt_busy;
    end
  end

  // Busy falls in the last counted cycle, so a waiting sequencer moves on exactly when the delay ends
  assign busy = busy_ff && !(msTick && (remain_ff == 15'h0001));

endmodule // ofr_delay_timer

// ===== verif/ofr_overtemp_monitor.sv
/* Checker of the over-temperature fault block, bound to its top module.
   Assumes TICK_CYCLES of at least 4 and a retry unit of at least one. */
`timescale 1ns/1ps
`include "ofr_defs.svh"

module ofr_overtemp_monitor #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Command port
  input wire logic        cmdValid,
  input wire logic        cmdWrite,
  input wire logic [7:0]  cmdCode,
  input wire logic [15:0] cmdWrData,
  input wire logic        cmdAck,
  input wire logic        cmdError,
  input wire logic [15:0] cmdRdData,
  // Measurement, on/off sources and outputs
  input wire logic [15:0] tempReading,
  input wire logic        ctrlPin,
  input wire logic        operationOn,
  input wire logic        biasGood,
  input wire logic        outputEnable,
  input wire logic        faultActive,
  input wire logic        retrying
);
  logic [15:0] thrFf;
  logic [15:0] nxt_thrFf;
  logic [7:0]  actFf;
  logic [7:0]  nxt_actFf;
  logic [2:0]  onFf;
  logic [2:0]  nxt_onFf;
  logic        hotOn;

  // Shadow copies; pin history covers the two-stage synchroniser
  always_comb begin
    nxt_thrFf = thrFf;
    nxt_actFf = actFf;
    nxt_onFf = {onFf[1:0], ctrlPin & biasGood};
    if (cmdValid && cmdWrite && cmdCode == `OFR_ADDR_THRESH) nxt_thrFf = cmdWrData;
    if (cmdValid && cmdWrite && cmdCode == `OFR_ADDR_ACTION) nxt_actFf = cmdWrData[7:0];
    hotOn = ctrlPin && biasGood && operationOn && (&onFf) && tempReading[15:11] == thrFf[15:11]
            && $signed(tempReading[10:0]) >= $signed(thrFf[10:0]);
  end

  always_ff @(posedge clk) begin
    thrFf <= resetn ? nxt_thrFf : `OFR_RST_THRESH;
    actFf <= resetn ? nxt_actFf : `OFR_RST_ACTION;
    onFf  <= resetn ? nxt_onFf : 3'h0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_heldOff;
    !outputEnable [*3];
  endsequence

  property p_ack;
    cmdValid |=> cmdAck;
  endproperty
  a_ack: assert property (p_ack) else $error("command not answered");

  property p_noAck;
    !cmdValid |=> !cmdAck && !cmdError;
  endproperty
  a_noAck: assert property (p_noAck) else $error("answer without command");

  property p_thrRd;
    cmdValid && !cmdWrite && cmdCode == `OFR_ADDR_THRESH |=> cmdRdData == thrFf;
  endproperty
  a_thrRd: assert property (p_thrRd) else $error("threshold read wrong");

  property p_hot;
    hotOn |=> faultActive;
  endproperty
  a_hot: assert property (p_hot) else $error("fault not declared");

  property p_ignore;
    actFf[7:6] == 2'h0 && outputEnable && hotOn |=> outputEnable;
  endproperty
  a_ignore: assert property (p_ignore) else $error("output dropped while ignoring");

  property p_disable;
    actFf[7] && hotOn && outputEnable |=> !outputEnable;
  endproperty
  a_disable: assert property (p_disable) else $error("output not disabled");

  property p_latch;
    actFf[7:6] == 2'h3 && faultActive && !outputEnable && !cmdValid && hotOn && $past(operationOn)
      |=> !outputEnable;
  endproperty
  a_latch: assert property (p_latch) else $error("latched output came back");

  // Shortest retry delay is one unit of TICK_CYCLES, so three clocks off is a floor
  property p_space;
    $rose(retrying) && actFf[7:6] == 2'h2 |-> s_heldOff;
  endproperty
  a_space: assert property (p_space) else $error("restart too early");

  property p_noRetry;
    actFf[7:6] == 2'h2 && actFf[5:3] == `OFR_RETRY_NONE && faultActive |-> !retrying;
  endproperty
  a_noRetry: assert property (p_noRetry) else $error("retry with code zero");
endmodule // ofr_overtemp_monitor

bind ofr_overtemp_fault ofr_overtemp_monitor #(.TICK_CYCLES(TICK_CYCLES)) ofr_overtemp_monitor_i (
  .clk, .resetn, .cmdValid, .cmdWrite, .cmdCode, .cmdWrData, .cmdAck, .cmdError, .cmdRdData,
  .tempReading, .ctrlPin, .operationOn, .biasGood, .outputEnable, .faultActive, .retrying
);

// ===== verif/ofr_host_model.sv
/* Model of the management host that sends one command at a time.
   Assumes the answer comes exactly one clock after the request. */
`timescale 1ns/1ps

module ofr_host_model (
  // Clock
  input  wire logic        clk,
  // Command port
  output logic             cmdValid,
  output logic             cmdWrite,
  output logic [7:0]       cmdCode,
  output logic [15:0]      cmdWrData,
  input  wire logic        cmdAck,
  input  wire logic        cmdError,
  input  wire logic [15:0] cmdRdData
);
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode = 8'h00;
    cmdWrData = 16'h0000;
  end

  // Clear requests travel as plain writes of the clear code
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                      output logic [15:0] rd, output logic ack, output logic err);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    cmdCode <= code;
    cmdWrData <= data;
    @(posedge clk);
    cmdValid <= 1'b0;
    // Idle bus shows the inverse so a stale word never passes for a fresh one
    cmdCode <= ~code;
    cmdWrData <= ~data;
    cmdWrite <= ~wr;
    #1;
    rd = cmdRdData;
    ack = cmdAck;
    err = cmdError;
  endtask
endmodule // ofr_host_model

// ===== verif/tb.sv
/* Testbench of the over-temperature fault block, commands issued through the host model.
   Assumes TICK_CYCLES of 4, so one delay unit of one tick is four clocks. */
`timescale 1ns/1ps
`include "ofr_defs.svh"

module tb;
  localparam int TICK = 4;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        cmdValid, cmdWrite, cmdAck, cmdError, ack, err;
  logic [7:0]  cmdCode;
  logic [15:0] cmdWrData, cmdRdData, rd;
  logic [15:0] tempReading = 16'h0010;
  logic        ctrlPin = 1'b1;
  logic        operationOn = 1'b1;
  logic        biasGood = 1'b1;
  logic        otherFault = 1'b0;
  logic        outputEnable, faultActive, retrying;
  logic [2:0]  rc [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
  logic [2:0]  nx [4] = '{3'h0, 3'h0, 3'h1, 3'h2};
  int          bad_count = 0;
  int          tests_run = 0;
  int          rises, gap;

  always #12.5 clk = ~clk;

  ofr_overtemp_fault #(.TICK_CYCLES(TICK)) ofr_overtemp_fault_i (
    .clk(clk), .resetn(resetn), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
    .cmdWrData(cmdWrData), .cmdAck(cmdAck), .cmdError(cmdError), .cmdRdData(cmdRdData),
    .tempReading(tempReading), .otherFault(otherFault), .ctrlPin(ctrlPin), .operationOn(operationOn),
    .biasGood(biasGood), .outputEnable(outputEnable), .faultActive(faultActive), .retrying(retrying)
  );

  ofr_host_model ofr_host_model_i (
    .clk(clk), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWrData(cmdWrData),
    .cmdAck(cmdAck), .cmdError(cmdError), .cmdRdData(cmdRdData)
  );

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chkb(input string name, input logic exp, input logic got);
    chk(name, {15'h0, exp}, {15'h0, got});
  endtask

  task automatic rdChk(input logic [7:0] code, input logic [15:0] exp);
    ofr_host_model_i.xfer(1'b0, code, 16'h0000, rd, ack, err);
    chkb("ack", 1'b1, ack);
    chk("rdata", exp, rd);
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    ofr_host_model_i.xfer(1'b1, code, data, rd, ack, err);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic heat(input logic [15:0] t);
    @(posedge clk);
    tempReading <= t;
  endtask

  // Counts output restarts and the spacing of the first two
  task automatic watch(input int n);
    int t0;
    logic prev;
    rises = 0;
    gap = 0;
    t0 = 0;
    prev = outputEnable;
    for (int i = 0; i < n; i++) begin
      cyc(1);
      if (outputEnable && !prev) begin
        rises++;
        if (rises == 1) t0 = i;
        if (rises == 2) gap = i - t0;
      end
      prev = outputEnable;
    end
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    cyc(4);
    rdChk(`OFR_ADDR_THRESH, `OFR_RST_THRESH);
    rdChk(`OFR_ADDR_ACTION, 16'(`OFR_RST_ACTION));
    rdChk(`OFR_ADDR_TIMING, `OFR_RST_TIMING);
    ofr_host_model_i.xfer(1'b0, 8'h33, 16'h0000, rd, ack, err);
    chkb("unmapped", 1'b1, err);
    wr(`OFR_ADDR_THRESH, 16'h0064);
    rdChk(`OFR_ADDR_THRESH, 16'h0064);
    wr(`OFR_ADDR_TIMING, 16'h0101);
    rdChk(`OFR_ADDR_TIMING, 16'h0101);
    wr(`OFR_ADDR_ACTION, 16'hFF00);
    rdChk(`OFR_ADDR_ACTION, 16'h0000);
    heat(16'h0064);
    cyc(3);
    chkb("fault", 1'b1, faultActive);
    chkb("out", 1'b1, outputEnable);
    heat(16'h0010);
    wr(`OFR_ADDR_STATUS, 16'h0001);
    cyc(2);
    chkb("fault", 1'b0, faultActive);
    wr(`OFR_ADDR_ACTION, 16'h0048);
    heat(16'h0064);
    cyc(3);
    chkb("out", 1'b1, outputEnable);
    cyc(20);
    chkb("out", 1'b0, outputEnable);
    heat(16'h0010);
    wr(`OFR_CMD_CLEAR, 16'h0000);
    cyc(4);
    chkb("out", 1'b1, outputEnable);
    for (int k = 0; k < 4; k++) begin
      wr(`OFR_ADDR_ACTION, {8'h00, 2'b10, rc[k], nx[k]});
      heat(16'h0064);
      watch(300);
      if (k == 3) chkb("many", 1'b1, rises > 6);
      else chk("attempts", {13'h0, rc[k]}, rises[15:0]);
      if (k > 1) chk("gap", 16'(TICK << nx[k]), gap[15:0]);
      if (k < 3) chkb("out", 1'b0, outputEnable);
      if (k == 3) begin
        @(posedge clk);
        operationOn <= 1'b0;
        cyc(4);
        chkb("retrying", 1'b0, retrying);
      end
      heat(16'h0010);
      if (k == 3) begin
        @(posedge clk);
        operationOn <= 1'b1;
      end else wr(`OFR_CMD_CLEAR, 16'h0000);
      cyc(4);
      chkb("fault", 1'b0, faultActive);
      chkb("out", 1'b1, outputEnable);
    end
    // Another protection tripping mid-sequence ends endless retries
    wr(`OFR_ADDR_ACTION, 16'h00BA);
    heat(16'h0064);
    cyc(30);
    @(posedge clk);
    otherFault <= 1'b1;
    @(posedge clk);
    otherFault <= 1'b0;
    cyc(8);
    chkb("retrying", 1'b0, retrying);
    chkb("out", 1'b0, outputEnable);
    heat(16'h0010);
    wr(`OFR_CMD_CLEAR, 16'h0000);
    cyc(4);
    chkb("out", 1'b1, outputEnable);
    wr(`OFR_ADDR_ACTION, 16'h00C0);
    heat(16'h0064);
    cyc(3);
    chkb("out", 1'b0, outputEnable);
    heat(16'h0010);
    cyc(40);
    chkb("out", 1'b0, outputEnable);
    rdChk(`OFR_ADDR_STATUS, 16'h0003);
    @(posedge clk);
    biasGood <= 1'b0;
    cyc(4);
    @(posedge clk);
    biasGood <= 1'b1;
    cyc(5);
    chkb("fault", 1'b0, faultActive);
    chkb("out", 1'b1, outputEnable);
    end_sim;
  end

  // Whole run is under two thousand clocks; this bound is far past it
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim;
  end
endmodule // tb
